// [rtl/chan_reset_params.svh]
// Constants for the channel reset endpoints and central sequencer
`ifndef CHAN_RESET_PARAMS_SVH
`define CHAN_RESET_PARAMS_SVH

`define NUM_CHANNELS     4
`define NUM_REQS         8
`define OSC_FREQ_MHZ     25
`define STEP_TIME_NS     200
`define STEP_CYCLES      ((`STEP_TIME_NS * `OSC_FREQ_MHZ + 999) / 1000)
`define REQ_IDX_TX_ANA   0
`define REQ_IDX_TX_DIG   1
`define REQ_IDX_RX_ANA   2
`define REQ_IDX_RX_DIG   3
`define RESET_ASSERTED   1'b1

`endif

// [rtl/chan_reset_pkg.sv]
// Types shared by the channel reset endpoints and sequencer
`include "chan_reset_params.svh"

package chan_reset_pkg;

    // Four reset requests of one channel
    typedef struct packed {
        logic rxDig;
        logic rxAna;
        logic txDig;
        logic txAna;
    } reset_req_t;

    // Clock recovery lock mode controls
    typedef struct packed {
        logic lockToRef;
        logic lockToData;
    } cdr_ctrl_t;

    typedef enum logic [1:0] {
        CDR_AUTO = 2'h0,
        CDR_REF  = 2'h1,
        CDR_DATA = 2'h3
    } cdr_mode_t;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'h0,
        SEQ_APPLY = 2'h1,
        SEQ_ACK   = 2'h3
    } seq_state_t;

endpackage

// [rtl/transceiver_channel_reset_control.sv]
// Reset endpoints and one shared sequencer for transceiver channels
// Rules for this block and its user reset controller
// [RULE_01] Controller fully resets each channel after power-up and configuration.
// [RULE_02] Controller holds TX in reset during PLL reconfiguration, then resets.
// [RULE_03] Controller holds TX in reset before PLL recalibration starts.
// [RULE_04] Controller resets the channel after reference clock frequency changes.
// [RULE_05] Controller resets the channel on PLL lock loss or recovery.
// [RULE_06] Controller holds channel in reset through rate-changing reconfiguration.
// [RULE_07] Controller resets RX when an optical module is connected.
// [RULE_08] Controller resets RX when recovery moves from reference to data lock.
// [RULE_09] TX and RX reset separately or jointly, each with analog and digital.
// [RULE_10] A full sequence also resets and initialises the driving PLL.
// [RULE_11] Controller may OR PLL and TX calibration busy into one input.
// [RULE_12] Analog and digital inputs feed a TX endpoint and an RX endpoint.
// [RULE_13] Endpoints forward every request to the central sequencer.
// [RULE_14] Sequencer schedules PCS and PMA resets and acknowledges each request.
// [RULE_15] One sequencer serves all channels and has no user control.
// [RULE_16] Sequencer clock comes from an internal oscillator, no user clock.
// [RULE_17] Controller keeps minimum spacing between reset request transitions.
// [RULE_18] Controller waits analog ack low, then PLL lock, before TX digital.
// [RULE_19] RX digital released after data lock held 5 us, restarting on toggle.
// [RULE_20] Controller asserts RX resets only while RX calibration is idle.
// [RULE_21] Two controls pick automatic, reference-forced or data-forced lock.
// [RULE_22] Controller keeps digital reset asserted while analog reset is asserted.
`include "chan_reset_params.svh"
`timescale 1ns/10ps
`default_nettype none

module transceiver_channel_reset_control
    import chan_reset_pkg::*;
(
    // Internal oscillator clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         reset_n,
    // Reset requests from the user controller, one set per channel
    input  wire reset_req_t [`NUM_CHANNELS-1:0] resetReq,
    // Clock recovery lock controls, one pair per channel
    input  wire cdr_ctrl_t  [`NUM_CHANNELS-1:0] cdrCtrl,
    // Acknowledge of each request, high while the reset is in force
    output var reset_req_t  [`NUM_CHANNELS-1:0] resetAck,
    // Resets applied to PMA and PCS
    output logic [`NUM_CHANNELS-1:0]          txPmaReset,
    output logic [`NUM_CHANNELS-1:0]          txPcsReset,
    output logic [`NUM_CHANNELS-1:0]          rxPmaReset,
    output logic [`NUM_CHANNELS-1:0]          rxPcsReset,
    // Selected lock mode per channel
    output var cdr_mode_t   [`NUM_CHANNELS-1:0] cdrMode
);

    localparam int NR = `NUM_CHANNELS * 4;
    localparam logic [7:0] STEP = 8'(`STEP_CYCLES);

    // Flat index of a request: channel times four plus kind
    function automatic int reqIndex(input int ch, input int kind);
        reqIndex = ch * 4 + kind;
    endfunction

    // Lock mode decode; data-lock control dominates
    function automatic cdr_mode_t decodeMode(input cdr_ctrl_t c);
        if (c.lockToData) begin
            decodeMode = CDR_DATA;
        end else if (c.lockToRef) begin
            decodeMode = CDR_REF;
        end else begin
            decodeMode = CDR_AUTO;
        end
    endfunction

    //==========================================================
    // Endpoints: flatten requests for the sequencer
    logic [NR-1:0] epReq;
    logic [NR-1:0] applied;
    logic [NR-1:0] ackFlat;

    always_comb begin
        for (int c = 0; c < `NUM_CHANNELS; c++) begin
            // Requests go to the sequencer, never straight to the channel
            epReq[reqIndex(c, `REQ_IDX_TX_ANA)] = resetReq[c].txAna; // RULE_13
            epReq[reqIndex(c, `REQ_IDX_TX_DIG)] = resetReq[c].txDig; // RULE_12
            epReq[reqIndex(c, `REQ_IDX_RX_ANA)] = resetReq[c].rxAna; // RULE_12
            epReq[reqIndex(c, `REQ_IDX_RX_DIG)] = resetReq[c].rxDig; // RULE_09
        end
    end

    //==========================================================
    // Central sequencer: one scheduler, one change at a time
    seq_state_t    state;
    seq_state_t    next_state;
    logic [3:0]    slot;
    logic [7:0]    stepCnt;
    logic [3:0]    next_slot;
    logic          pending;

    // Round robin search for a request whose level differs from applied
    always_comb begin
        next_slot = slot;
        pending   = 1'b0;
        for (int k = NR; k >= 1; k--) begin
            if (epReq[4'(slot + 4'(k))] != applied[4'(slot + 4'(k))]) begin
                next_slot = 4'(slot + 4'(k));
                pending   = 1'b1;
            end
        end
    end

    // Next state: a step ends when its count runs out
    always_comb begin
        next_state = state;
        unique case (state)
            SEQ_IDLE: begin
                if (pending) begin
                    next_state = SEQ_APPLY;
                end
            end
            SEQ_APPLY: begin
                // Spacing keeps PMA and PCS steps apart
                if (stepCnt == 8'h01) begin
                    next_state = SEQ_ACK; // RULE_14
                end
            end
            SEQ_ACK: begin
                next_state = SEQ_IDLE;
            end
            default: begin
                // Unused code falls back to idle
                next_state = SEQ_IDLE;
            end
        endcase
    end

    // Single shared instance with no user-visible control
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= SEQ_IDLE; // RULE_15
        end else begin
            state <= next_state;
        end
    end

    // Slot moves only when a new request is taken
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            slot <= 4'h0;
        end else if (state == SEQ_IDLE && pending) begin
            slot <= next_slot;
        end
    end

    // Step counter loads on take, counts down while applying
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stepCnt <= 8'h00;
        end else if (state == SEQ_IDLE && pending) begin
            stepCnt <= STEP;
        end else if (state == SEQ_APPLY && stepCnt != 8'h01) begin
            stepCnt <= stepCnt - 8'h01;
        end
    end

    // Applied level follows the request once its step is done
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            applied <= '1;
        end else if (state == SEQ_ACK) begin
            applied[slot] <= epReq[slot]; // RULE_14
        end
    end

    // Acknowledge mirrors the applied state of each request
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ackFlat <= '1;
        end else begin
            ackFlat <= applied; // RULE_14
        end
    end

    //==========================================================
    // Outputs to channels
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            txPmaReset <= '1;
            txPcsReset <= '1;
        end else begin
            for (int c = 0; c < `NUM_CHANNELS; c++) begin
                txPmaReset[c] <= applied[reqIndex(c, `REQ_IDX_TX_ANA)];
                txPcsReset[c] <= applied[reqIndex(c, `REQ_IDX_TX_DIG)];
            end
        end
    end

    // Receive side resets, same one-cycle lag as transmit
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rxPmaReset <= '1;
            rxPcsReset <= '1;
        end else begin
            for (int c = 0; c < `NUM_CHANNELS; c++) begin
                rxPmaReset[c] <= applied[reqIndex(c, `REQ_IDX_RX_ANA)];
                rxPcsReset[c] <= applied[reqIndex(c, `REQ_IDX_RX_DIG)];
            end
        end
    end

    // Lock mode is not sequenced; it follows its controls directly
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cdrMode <= '{default: CDR_AUTO};
        end else begin
            for (int c = 0; c < `NUM_CHANNELS; c++) begin
                cdrMode[c] <= decodeMode(cdrCtrl[c]); // RULE_21
            end
        end
    end

    always_comb begin
        for (int c = 0; c < `NUM_CHANNELS; c++) begin
            resetAck[c].txAna = ackFlat[reqIndex(c, `REQ_IDX_TX_ANA)];
            resetAck[c].txDig = ackFlat[reqIndex(c, `REQ_IDX_TX_DIG)];
            resetAck[c].rxAna = ackFlat[reqIndex(c, `REQ_IDX_RX_ANA)];
            resetAck[c].rxDig = ackFlat[reqIndex(c, `REQ_IDX_RX_DIG)];
        end
    end

    // sys_clk is the internal oscillator; no user clock enters here // RULE_16

endmodule

`default_nettype wire

// [tb/user_reset_model.sv]
// User reset controller model facing the reset endpoints
`timescale 1ns/10ps
`default_nettype none
`include "chan_reset_params.svh"
module user_reset_model
    import chan_reset_pkg::*;
(
    // Clock and commanded levels
    input  wire logic                           sys_clk,
    input  wire reset_req_t [`NUM_CHANNELS-1:0] want,
    // Requests to the endpoints
    output var reset_req_t  [`NUM_CHANNELS-1:0] resetReq
);
    // Calibration busy taken as one ORed level, idle in this model
    // Digital held whenever analog is, so PCS never leaves reset early
    always_ff @(posedge sys_clk) begin
        for (int c = 0; c < `NUM_CHANNELS; c++) begin
            resetReq[c].txAna <= want[c].txAna;
            resetReq[c].rxAna <= want[c].rxAna;
            resetReq[c].txDig <= want[c].txDig | want[c].txAna;
            resetReq[c].rxDig <= want[c].rxDig | want[c].rxAna;
        end
    end
endmodule
`default_nettype wire

// [tb/chan_reset_monitor.sv]
// Assertion checker for the channel reset block
`timescale 1ns/10ps
`default_nettype none
`include "chan_reset_params.svh"
module chan_reset_monitor
    import chan_reset_pkg::*;
(
    // Clock, reset and requests
    input wire logic                           sys_clk,
    input wire logic                           reset_n,
    input wire reset_req_t [`NUM_CHANNELS-1:0] resetReq,
    input wire cdr_ctrl_t  [`NUM_CHANNELS-1:0] cdrCtrl,
    // Block outputs
    input wire reset_req_t [`NUM_CHANNELS-1:0] resetAck,
    input wire logic [`NUM_CHANNELS-1:0]       txPmaReset,
    input wire logic [`NUM_CHANNELS-1:0]       txPcsReset,
    input wire logic [`NUM_CHANNELS-1:0]       rxPmaReset,
    input wire logic [`NUM_CHANNELS-1:0]       rxPcsReset,
    input wire cdr_mode_t  [`NUM_CHANNELS-1:0] cdrMode
);
    wire [4*`NUM_CHANNELS-1:0] applied;
    assign applied = {txPmaReset, txPcsReset, rxPmaReset, rxPcsReset};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ========================================
    // Properties
    property p_rst; $rose(reset_n) |-> &resetAck && &applied; endproperty
    property p_ack; $changed(txPmaReset[0]) |=>
        resetAck[0].txAna == txPmaReset[0]; endproperty
    property p_pcs; $changed(rxPcsReset[3]) |=>
        resetAck[3].rxDig == rxPcsReset[3]; endproperty
    property p_take; $fell(txPmaReset[0]) |->
        !$past(resetReq[0].txAna, 7); endproperty
    property p_one; $changed(resetAck) |->
        $onehot(resetAck ^ $past(resetAck)); endproperty
    property p_space; $changed(applied) |=> $stable(applied)[*6]; endproperty
    property p_data; cdrCtrl[1].lockToData |=> cdrMode[1] == CDR_DATA;
    endproperty
    property p_ref; cdrCtrl[1] == 2'h2 |=> cdrMode[1] == CDR_REF; endproperty
    property p_auto; cdrCtrl[1] == 2'h0 |=> cdrMode[1] == CDR_AUTO;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_ack: assert property (p_ack) else $error("tx ack lag");
    a_pcs: assert property (p_pcs) else $error("rx ack lag");
    a_take: assert property (p_take) else $error("bad take");
    a_one: assert property (p_one) else $error("two acks");
    a_space: assert property (p_space) else $error("overlap");
    a_data: assert property (p_data) else $error("data mode");
    a_ref: assert property (p_ref) else $error("ref mode");
    a_auto: assert property (p_auto) else $error("auto mode");
    c_tx: cover property ($fell(txPmaReset[0]));
    c_rx: cover property ($fell(rxPcsReset[3]));
    c_cdr: cover property (cdrMode[1] == CDR_REF);
endmodule
bind transceiver_channel_reset_control chan_reset_monitor
    chan_reset_monitor_inst (.sys_clk, .reset_n, .resetReq, .cdrCtrl,
    .resetAck, .txPmaReset, .txPcsReset, .rxPmaReset, .rxPcsReset, .cdrMode);
`default_nettype wire

// [tb/transceiver_channel_reset_control_bench.sv]
// Self-checking bench for the channel reset block
`timescale 1ns/10ps
`default_nettype none
`include "chan_reset_params.svh"
module transceiver_channel_reset_control_bench
    import chan_reset_pkg::*;
;
    logic sys_clk, reset_n;
    reset_req_t [`NUM_CHANNELS-1:0] want, resetReq, resetAck;
    cdr_ctrl_t [`NUM_CHANNELS-1:0] cdrCtrl;
    cdr_mode_t [`NUM_CHANNELS-1:0] cdrMode;
    logic [`NUM_CHANNELS-1:0] txPmaReset, txPcsReset, rxPmaReset, rxPcsReset;
    int bad_count = 0;
    int num_checks = 0;
    user_reset_model user_reset_model_inst (.sys_clk, .want, .resetReq);
    transceiver_channel_reset_control transceiver_channel_reset_control_inst
        (.sys_clk, .reset_n, .resetReq, .cdrCtrl, .resetAck, .txPmaReset,
        .txPcsReset, .rxPmaReset, .rxPcsReset, .cdrMode);
    initial begin
        sys_clk = 0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits for acks; one call may change several requests at once, and the sequencer spaces them
    task automatic go(input logic [15:0] w, input logic [15:0] ack);
        want <= w;
        for (int i = 0; i < 60 && resetAck !== ack; i++) @(posedge sys_clk);
        chk(resetAck, ack);
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        chk(resetAck, 16'hFFFF);
        chk({txPmaReset, txPcsReset, rxPmaReset, rxPcsReset}, 16'hFFFF);
    endtask
    task automatic t_tx_split();
        go(16'hFFFE, 16'hFFFE);
        chk({txPmaReset, txPcsReset}, 8'hEF);
        go(16'hFFFC, 16'hFFFC);
        chk({txPmaReset, txPcsReset}, 8'hEE);
    endtask
    task automatic t_rx_joint();
        go(16'h3FFC, 16'h3FFC);
        chk({rxPmaReset, rxPcsReset}, 8'h77);
    endtask
    task automatic t_reassert();
        go(16'h3FFD, 16'h3FFF);
        chk({txPmaReset, txPcsReset, rxPmaReset}, 12'hFF7);
    endtask
    task automatic t_cdr();
        logic [1:0] ctl [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
        cdr_mode_t md [4] = '{CDR_REF, CDR_DATA, CDR_DATA, CDR_AUTO};
        for (int i = 0; i < 4; i++) begin
            cdrCtrl[1] <= ctl[i];
            repeat (3) @(posedge sys_clk);
            chk(16'(cdrMode[1]), 16'(md[i]));
        end
    endtask
    initial begin
        reset_n <= 0;
        want <= '1;
        cdrCtrl <= '0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1;
        @(posedge sys_clk);
        t_reset();
        t_tx_split();
        t_rx_joint();
        t_reassert();
        t_cdr();
        wrap_up();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #2000000;
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
